// ---- testbench/spi_pin_gpio_monitor.sv ----
// Checker: bus response, reserved bits, pin values and reset state of the pin latch
module spi_pin_gpio_monitor #(
    parameter int CS_PINS = 8
) (
    // Clock, reset and bus
    input wire logic                aclk, aresetn, s_axi_awvalid, s_axi_awready,
    input wire logic                s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_rvalid,
    input wire logic [31:0]         s_axi_awaddr, s_axi_wdata, s_axi_rdata,
    input wire logic [3:0]          s_axi_wstrb,
    input wire logic [1:0]          s_axi_bresp,
    // Pins
    input wire logic                slave_out_pin_o, slave_out_pin_oe_n, slave_in_pin_o,
    input wire logic                slave_in_pin_oe_n, serial_clock_pin_o, serial_clock_pin_oe_n,
    input wire logic                handshake_pin_o, handshake_pin_oe_n,
    input wire logic [CS_PINS-1:0]  chip_select_pins_o, chip_select_pins_oe_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Address and data taken together at the data register
    sequence s_wr0;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr[3:0] == 4'h0;
    endsequence
    // Register updates one edge after the take, pins one edge later still
    property p_reserved; s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h00000; endproperty
    a_reserved: assert property (p_reserved) else $error("upper bits read nonzero");
    property p_resp; s_wr0 |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h0; endproperty
    a_resp: assert property (p_resp) else $error("data write not answered okay");
    property p_slave_out;
        s_wr0 ##0 (s_axi_wstrb[1] && !slave_out_pin_oe_n)
            |-> ##3 slave_out_pin_o == $past(s_axi_wdata[11], 3);
    endproperty
    a_slave_out: assert property (p_slave_out) else $error("slave-out pin wrong");
    property p_slave_in;
        s_wr0 ##0 (s_axi_wstrb[1] && !slave_in_pin_oe_n)
            |-> ##3 slave_in_pin_o == $past(s_axi_wdata[10], 3);
    endproperty
    a_slave_in: assert property (p_slave_in) else $error("slave-in pin wrong");
    property p_clock;
        s_wr0 ##0 (s_axi_wstrb[1] && !serial_clock_pin_oe_n)
            |-> ##3 serial_clock_pin_o == $past(s_axi_wdata[9], 3);
    endproperty
    a_clock: assert property (p_clock) else $error("clock pin wrong");
    property p_handshake;
        s_wr0 ##0 (s_axi_wstrb[1] && !handshake_pin_oe_n)
            |-> ##3 handshake_pin_o == $past(s_axi_wdata[8], 3);
    endproperty
    a_handshake: assert property (p_handshake) else $error("handshake pin wrong");
    property p_cs;
        s_wr0 ##0 s_axi_wstrb[0] |-> ##3 (chip_select_pins_o & ~chip_select_pins_oe_n)
            == ($past(s_axi_wdata[CS_PINS-1:0], 3) & ~chip_select_pins_oe_n);
    endproperty
    a_cs: assert property (p_cs) else $error("chip-select pins wrong");
    // Reset must release every pin even though the other checks are disabled meanwhile
    property p_reset;
        @(posedge aclk) disable iff (1'b0) !aresetn |=> slave_out_pin_oe_n && slave_in_pin_oe_n
            && serial_clock_pin_oe_n && handshake_pin_oe_n && (&chip_select_pins_oe_n) && !s_axi_bvalid;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule // spi_pin_gpio_monitor

// ---- testbench/testbench.sv ----
// Testbench: reset, then register table rows, strobe, unmapped and mid-run reset cases
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", n, e, a); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, slave_out_pin_o, slave_out_pin_oe_n, slave_in_pin_o;
    logic        slave_in_pin_oe_n, serial_clock_pin_o, serial_clock_pin_oe_n;
    logic        handshake_pin_o, handshake_pin_oe_n;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [7:0]  chip_select_pins_o, chip_select_pins_oe_n;
    wire  [11:0] pin_o = {slave_out_pin_o, slave_in_pin_o, serial_clock_pin_o, handshake_pin_o,
                          chip_select_pins_o};
    wire  [11:0] pin_oe_n = {slave_out_pin_oe_n, slave_in_pin_oe_n, serial_clock_pin_oe_n,
                             handshake_pin_oe_n, chip_select_pins_oe_n};
    int          n_fail = 0, n_tests = 0;
    typedef struct { logic [11:0] fn, dir, dat; } row_t;
    row_t rows [4] = '{'{12'h000, 12'hFFF, 12'hA5C}, '{12'h000, 12'hFFF, 12'h5A3},
                       '{12'hF0F, 12'hFFF, 12'hFFF}, '{12'h0F0, 12'h3C3, 12'h9E7}};
    always #5 aclk = ~aclk;
    spi_pin_gpio_data_out #(.CS_PINS(8)) spi_pin_gpio_data_out_inst (.*);
    task wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] q);
        @(posedge aclk);
        s_axi_awaddr <= {28'h0000000, a}; s_axi_awvalid <= 1; s_axi_bready <= 1;
        s_axi_wdata <= v; s_axi_wstrb <= s; s_axi_wvalid <= 1;
        fork
            begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 0; end
            begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 0; end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        q = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] q);
        @(posedge aclk);
        s_axi_araddr <= {28'h0000000, a}; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        v = s_axi_rdata; q = s_axi_rresp;
        s_axi_rready <= 0;
        #1;
    endtask
    task reset_dut;
        @(posedge aclk);
        aresetn <= 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
    endtask
    task check_reset;
        rd(4'h0, d, r);
        `CHK("reset data", 32'h00000000, d)
        `CHK("reset enables", 12'hFFF, pin_oe_n)
        `CHK("reset pins", 12'h000, pin_o)
    endtask
    task summarize;
        $display("counts: %0d compares, %0d mismatches", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        reset_dut;
        check_reset;
        $display("test reset done");
        // Upper ones in every data write must be dropped
        foreach (rows[i]) begin
            wr(4'h4, {20'h00000, rows[i].fn}, 4'hF, r);
            wr(4'h8, {20'h00000, rows[i].dir}, 4'hF, r);
            wr(4'h0, {20'hFFFFF, rows[i].dat}, 4'hF, r);
            rd(4'h0, d, r);
            `CHK("readback", {20'h00000, rows[i].dat}, d)
            `CHK("enables", ~(~rows[i].fn & rows[i].dir), pin_oe_n)
            `CHK("pins", rows[i].dat & ~rows[i].fn & rows[i].dir, pin_o)
            $display("test row %0d done", i);
        end
        wr(4'h0, 32'h00000000, 4'h2, r);
        rd(4'h0, d, r);
        `CHK("upper strobe only", 32'h000000E7, d)
        wr(4'hC, 32'hFFFFFFFF, 4'hF, r);
        `CHK("unmapped write", pin_gpio_pkg::RESP_SLVERR, r)
        rd(4'hC, d, r);
        `CHK("unmapped read", pin_gpio_pkg::RESP_SLVERR, r)
        rd(4'h0, d, r);
        `CHK("data kept", 32'h000000E7, d)
        $display("test strobe and unmapped done");
        reset_dut;
        check_reset;
        $display("test second reset done");
        summarize;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        $display("Error watchdog expected done seen hang");
        summarize;
    end
endmodule // testbench
bind spi_pin_gpio_data_out spi_pin_gpio_monitor #(.CS_PINS(CS_PINS)) spi_pin_gpio_monitor_inst (.*);

// ---- verilog/pin_gpio_pkg.sv ----
// Package: register map and field layout of the pin output data latch
package pin_gpio_pkg;
    localparam int          ADDR_W           = 4;
    // Register byte offsets
    localparam logic [3:0]  OFF_OUTPUT_DATA  = 4'h0;
    localparam logic [3:0]  OFF_PIN_FUNCTION = 4'h4;
    localparam logic [3:0]  OFF_PIN_DIRECTION = 4'h8;
    // Field positions
    localparam int          POS_SLAVE_OUT    = 11;
    localparam int          POS_SLAVE_IN     = 10;
    localparam int          POS_SERIAL_CLOCK = 9;
    localparam int          POS_HANDSHAKE    = 8;
    localparam int          POS_CHIP_SELECT  = 0;
    localparam int          NUM_PINS         = 12;
    // Reset values
    localparam logic [11:0] RESET_OUTPUT_DATA = 12'h000;
    localparam logic [11:0] RESET_PIN_CONFIG  = 12'h000;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage

// ---- verilog/spi_pin_gpio_data_out.sv ----
// Output data latch for serial port pins used as general-purpose outputs
// Functional notes
// - Bits 31-12 of the output data register read as zero and ignore writes.
// - Bit 11 holds the slave-out value, driven on that pin only when it is a GPIO output.
// - Bit 10 holds the slave-in value, driven on that pin only when it is a GPIO output.
// - Bit 9 holds the serial clock value, driven on that pin only when it is a GPIO output.
// - Bit 8 holds the handshake value, driven on that pin only when it is a GPIO output.
// - Bits 7-0 hold one chip-select value each, driven on pin n only when it is a GPIO output.
// - A stored 0 drives the pin low and a stored 1 drives it high.
// - Reset clears every writable data bit and every reserved bit to zero.
module spi_pin_gpio_data_out #(
    parameter int CS_PINS = 8
) (
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite write address
    input  wire logic [31:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Pins: value, and output enable (low while driving)
    output logic                     slave_out_pin_o,
    output logic                     slave_out_pin_oe_n,
    output logic                     slave_in_pin_o,
    output logic                     slave_in_pin_oe_n,
    output logic                     serial_clock_pin_o,
    output logic                     serial_clock_pin_oe_n,
    output logic                     handshake_pin_o,
    output logic                     handshake_pin_oe_n,
    output logic [CS_PINS-1:0]       chip_select_pins_o,
    output logic [CS_PINS-1:0]       chip_select_pins_oe_n
);

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic [3:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [11:0] pin_output_data;
        logic [11:0] pin_function;
        logic [11:0] pin_direction;
        logic [11:0] pin_value;
        logic [11:0] pin_oe_n;
    } state_t;

    state_t state;
    state_t next_state;

    // Applies byte strobes to the low 12 bits; upper bits are dropped
    function automatic logic [11:0] merge12(input logic [11:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [11:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[11:8] = data[11:8];
        end
        return res;
    endfunction

    // Writable chip-select positions beyond CS_PINS stay zero
    localparam logic [11:0] DATA_MASK = 12'hF00 | 12'((1 << CS_PINS) - 1);

    always_comb begin
        logic [11:0] gpio_out;
        logic        do_write;
        gpio_out   = '0;
        do_write   = 1'b0;
        next_state = state;
        // Write channel: accept address and data in either order
        if (state.awready && s_axi_awvalid) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr[3:0];
            next_state.awready = 1'b0;
        end
        if (state.wready && s_axi_wvalid) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
            next_state.wready = 1'b0;
        end
        if (state.aw_held && state.w_held && !state.bvalid) begin
            do_write           = 1'b1;
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = pin_gpio_pkg::RESP_OKAY;
            case (state.aw_addr)
                pin_gpio_pkg::OFF_OUTPUT_DATA: begin
                    next_state.pin_output_data = merge12(state.pin_output_data,
                        state.w_data, state.w_strb) & DATA_MASK;
                end
                pin_gpio_pkg::OFF_PIN_FUNCTION: begin
                    next_state.pin_function = merge12(state.pin_function,
                        state.w_data, state.w_strb) & DATA_MASK;
                end
                pin_gpio_pkg::OFF_PIN_DIRECTION: begin
                    next_state.pin_direction = merge12(state.pin_direction,
                        state.w_data, state.w_strb) & DATA_MASK;
                end
                default: begin
                    next_state.bresp = pin_gpio_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid  = 1'b0;
            next_state.awready = 1'b1;
            next_state.wready  = 1'b1;
        end
        // Read channel: one read at a time, answered the cycle after the address
        if (state.arready && s_axi_arvalid) begin
            next_state.arready = 1'b0;
            next_state.rvalid  = 1'b1;
            next_state.rresp   = pin_gpio_pkg::RESP_OKAY;
            next_state.rdata   = '0;
            case (s_axi_araddr[3:0])
                pin_gpio_pkg::OFF_OUTPUT_DATA: begin
                    next_state.rdata[11:0] = state.pin_output_data;
                end
                pin_gpio_pkg::OFF_PIN_FUNCTION: begin
                    next_state.rdata[11:0] = state.pin_function;
                end
                pin_gpio_pkg::OFF_PIN_DIRECTION: begin
                    next_state.rdata[11:0] = state.pin_direction;
                end
                default: begin
                    next_state.rresp = pin_gpio_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid  = 1'b0;
            next_state.arready = 1'b1;
        end
        // Pins: a pin is driven only as GPIO (function 0) with direction output
        gpio_out = ~state.pin_function & state.pin_direction;
        next_state.pin_value = state.pin_output_data & gpio_out;
        next_state.pin_oe_n  = ~gpio_out;
        if (!aresetn) begin
            next_state                 = '0;
            next_state.pin_output_data = pin_gpio_pkg::RESET_OUTPUT_DATA;
            next_state.pin_function    = pin_gpio_pkg::RESET_PIN_CONFIG;
            next_state.pin_direction   = pin_gpio_pkg::RESET_PIN_CONFIG;
            next_state.pin_oe_n        = '1;
            next_state.awready         = 1'b1;
            next_state.wready          = 1'b1;
            next_state.arready         = 1'b1;
        end
        if (do_write && !aresetn) begin
            next_state.bvalid = 1'b0;
        end
    end

    // Timing seen from the bus side:
    //  - address and data are parked in aw_held / w_held on the edge they are taken
    //  - the register updates and bvalid rises one edge after both are parked
    //  - the pins follow one edge after the register, so every pin output
    //    comes straight from a flip-flop and never from the decode logic
    // The extra pin stage costs a cycle of latency; nothing in the pin path
    // is timing critical, and a registered pin cannot glitch when the
    // function and direction registers are rewritten in one burst.
    // Reset is synchronous: aresetn is sampled like any other input, so it
    // must be held across at least one rising edge of aclk.

    // Single state register; all next values are formed above
    always_ff @(posedge aclk) begin
        state <= next_state;
    end

    // Bus and pin outputs are plain taps of the state register

    assign s_axi_awready         = state.awready;
    assign s_axi_wready          = state.wready;
    assign s_axi_bvalid          = state.bvalid;
    assign s_axi_bresp           = state.bresp;
    assign s_axi_arready         = state.arready;
    assign s_axi_rvalid          = state.rvalid;
    assign s_axi_rdata           = state.rdata;
    assign s_axi_rresp           = state.rresp;
    assign slave_out_pin_o       = state.pin_value[pin_gpio_pkg::POS_SLAVE_OUT];
    assign slave_out_pin_oe_n    = state.pin_oe_n[pin_gpio_pkg::POS_SLAVE_OUT];
    assign slave_in_pin_o        = state.pin_value[pin_gpio_pkg::POS_SLAVE_IN];
    assign slave_in_pin_oe_n     = state.pin_oe_n[pin_gpio_pkg::POS_SLAVE_IN];
    assign serial_clock_pin_o    = state.pin_value[pin_gpio_pkg::POS_SERIAL_CLOCK];
    assign serial_clock_pin_oe_n = state.pin_oe_n[pin_gpio_pkg::POS_SERIAL_CLOCK];
    assign handshake_pin_o       = state.pin_value[pin_gpio_pkg::POS_HANDSHAKE];
    assign handshake_pin_oe_n    = state.pin_oe_n[pin_gpio_pkg::POS_HANDSHAKE];
    assign chip_select_pins_o    = state.pin_value[pin_gpio_pkg::POS_CHIP_SELECT +: CS_PINS];
    assign chip_select_pins_oe_n = state.pin_oe_n[pin_gpio_pkg::POS_CHIP_SELECT +: CS_PINS];

endmodule // spi_pin_gpio_data_out
